// ### src/frame_regs_pkg.sv
/*
  Package for the frame number and transmit clock register slice:
  register offsets, field positions, reset values and bus types.
  Assumes an 8-bit register space reached over classic Wishbone.
*/
package frame_regs_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned FRAME_W = 16;
  localparam int unsigned COUNT_W = 24;

  // Printed offsets are register indices; byte address is four times.
  localparam logic [5:0] IDX_TRIG_LOW_LSB = 6'h1c;
  localparam logic [5:0] IDX_WRAP_MSB = 6'h1d;
  localparam logic [5:0] IDX_WRAP_LSB = 6'h1e;
  localparam logic [5:0] IDX_CLK_CTL = 6'h1f;
  localparam logic [5:0] IDX_TRIG_LOW_MSB = 6'h1b;
  localparam logic [5:0] IDX_TRIG_HIGH_LSB = 6'h1a;
  localparam logic [5:0] IDX_TRIG_CTL = 6'h20;
  localparam logic [5:0] IDX_FRAME_NUM = 6'h21;

  localparam logic [7:0] RST_TRIG_LOW_LSB = 8'h00;
  localparam logic [7:0] RST_WRAP_MSB = 8'h00;
  localparam logic [7:0] RST_WRAP_LSB = 8'h04;
  localparam logic [7:0] RST_CLK_CTL = 8'h02;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] CLK_CTL_MASK = 8'h0f;

  localparam int unsigned BIT_OSC_SEL = 3;
  localparam int unsigned BIT_REF_MODE = 2;
  localparam int unsigned BIT_GEN_EN = 0;
  localparam int unsigned BIT_DUTY = 1;

  localparam logic [1:0] RATE_HIGH = 2'h0;
  localparam logic [1:0] RATE_1G2 = 2'h1;
  localparam logic [1:0] RATE_800M = 2'h2;
  localparam logic [1:0] RATE_400M = 2'h3;

  localparam logic [15:0] FRAME_ONE = 16'h0001;
  localparam logic [15:0] FRAME_ZERO = 16'h0000;
  localparam logic [23:0] COUNT_ZERO = 24'h000000;
  localparam logic [23:0] COUNT_ONE = 24'h000001;

  typedef struct packed {
    logic osc_sel;
    logic ref_half;
    logic [1:0] tx_rate;
  } clk_cfg_type;

  typedef struct packed {
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } wb_req_type;

endpackage : frame_regs_pkg

// ### src/trigger_gen.sv
/*
  Camera trigger waveform generator.
  Assumes counts are stable while enabled; a change also applies to
  the phase in progress, whose count is compared every cycle.
*/
`timescale 1ns/1ns
module trigger_gen
  import frame_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic duty_even,
  input wire logic [15:0] high_count,
  input wire logic [15:0] low_count,
  input wire logic [23:0] even_count,
  output logic trigger
);

  logic [COUNT_W-1:0] cnt_r;

  function automatic logic [COUNT_W-1:0] phase_len(input logic hi);
    if (duty_even) begin
      phase_len = even_count;
    end else if (hi) begin
      phase_len = {8'h00, high_count};
    end else begin
      phase_len = {8'h00, low_count};
    end
  endfunction : phase_len

  // Count runs to the programmed value, so a zero gives one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= COUNT_ZERO;
      trigger <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        cnt_r <= COUNT_ZERO;
        trigger <= 1'b0;
      end else if (cnt_r >= phase_len(trigger)) begin
        cnt_r <= COUNT_ZERO;
        trigger <= ~trigger;
      end else begin
        cnt_r <= cnt_r + COUNT_ONE;
      end
    end
  end

endmodule : trigger_gen

// ### src/frame_regs.sv
/*
  Register slice: trigger low count, frame wrap limit, frame numbering
  for raw-mode frames, and transmit clock control, on classic Wishbone.
  Assumes the frame builder pulses frame_start once per frame and
  samples frame_number with its start and end packets.
*/
// Contract
// - Low-count lsb register holds bits 7:0
// - Programmed count is cycles minus one
// - Wrap limit msb register holds bits 15:8
// - Wrap limit lsb holds 7:0, resets four
// - Sixteen-bit number in every start/end packet
// - Zero limit disables numbering, number zero
// - Nonzero limit counts 1 to max, repeats
// - Oscillator select: 0 external, 1 internal
// - Reference mode: 0 full, 1 half rate
// - Two-bit lane rate field, resets 800M
// - Hi/Lo mode uses 16-bit low count
// - 50/50 mode uses combined 24-bit count
`timescale 1ns/1ns
module frame_regs
  import frame_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic raw_mode,
  input wire logic frame_start,
  output logic [FRAME_W-1:0] frame_number,
  output logic frame_number_valid,
  output logic internal_oscillator_select,
  output logic ref_clk_half,
  output logic [1:0] lane_rate,
  output logic camera_trigger_signal
);

  ////////////////////////////////////////////////////////////////////
  // Bus decode

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_type;

  bus_state_type bus_r;
  wb_req_type req;
  logic [5:0] idx;
  logic take;
  logic wr_lane0;

  assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i,
                 we: wb_we_i, cyc: wb_cyc_i, stb: wb_stb_i};
  assign idx = req.adr[ADDR_W-1:2];
  assign take = req.cyc && req.stb && (bus_r == BUS_IDLE);
  assign wr_lane0 = take && req.we && req.sel[0];

  function automatic logic hit(input logic [5:0] which);
    hit = wr_lane0 && (idx == which);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////
  // Registers

  logic [REG_W-1:0] trig_low_lsb_r;
  logic [REG_W-1:0] trig_low_msb_r;
  logic [REG_W-1:0] trig_high_lsb_r;
  logic [REG_W-1:0] trig_ctl_r;
  logic [REG_W-1:0] wrap_msb_r;
  logic [REG_W-1:0] wrap_lsb_r;
  clk_cfg_type clk_cfg_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_low_lsb_r <= RST_TRIG_LOW_LSB;
      trig_low_msb_r <= RST_ZERO;
      trig_high_lsb_r <= RST_ZERO;
      trig_ctl_r <= RST_ZERO;
    end else if (ce) begin
      if (hit(IDX_TRIG_LOW_LSB)) begin
        trig_low_lsb_r <= req.dat[7:0];
      end
      if (hit(IDX_TRIG_LOW_MSB)) begin
        trig_low_msb_r <= req.dat[7:0];
      end
      if (hit(IDX_TRIG_HIGH_LSB)) begin
        trig_high_lsb_r <= req.dat[7:0];
      end
      if (hit(IDX_TRIG_CTL)) begin
        trig_ctl_r <= req.dat[7:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrap_msb_r <= RST_WRAP_MSB;
      wrap_lsb_r <= RST_WRAP_LSB;
    end else if (ce) begin
      if (hit(IDX_WRAP_MSB)) begin
        wrap_msb_r <= req.dat[7:0];
      end
      if (hit(IDX_WRAP_LSB)) begin
        wrap_lsb_r <= req.dat[7:0];
      end
    end
  end

  // Upper nibble is dropped on write and never stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_cfg_r <= clk_cfg_type'(RST_CLK_CTL[3:0]);
    end else if (ce) begin
      if (hit(IDX_CLK_CTL)) begin
        clk_cfg_r <= clk_cfg_type'(req.dat[3:0]);
      end
    end
  end

  // Outputs are plain copies so the clock muxes see only flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      internal_oscillator_select <= RST_CLK_CTL[BIT_OSC_SEL];
      ref_clk_half <= RST_CLK_CTL[BIT_REF_MODE];
      lane_rate <= RST_CLK_CTL[1:0];
    end else if (ce) begin
      internal_oscillator_select <= clk_cfg_r.osc_sel;
      // Half rate with 400M is software's to avoid; not blocked here
      ref_clk_half <= clk_cfg_r.ref_half;
      lane_rate <= clk_cfg_r.tx_rate;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Frame numbering

  logic [FRAME_W-1:0] wrap_limit;
  logic [FRAME_W-1:0] frame_num_r;
  logic [FRAME_W-1:0] frame_num_nxt;

  assign wrap_limit = {wrap_msb_r, wrap_lsb_r};

  always_comb begin
    if (wrap_limit == FRAME_ZERO) begin
      frame_num_nxt = FRAME_ZERO;
    end else if (frame_num_r >= wrap_limit) begin
      // Also catches a limit lowered below the current number
      frame_num_nxt = FRAME_ONE;
    end else begin
      frame_num_nxt = frame_num_r + FRAME_ONE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_num_r <= FRAME_ZERO;
      frame_number <= FRAME_ZERO;
      frame_number_valid <= 1'b0;
    end else if (ce) begin
      frame_number_valid <= raw_mode;
      if (wrap_limit == FRAME_ZERO) begin
        frame_num_r <= FRAME_ZERO;
        frame_number <= FRAME_ZERO;
      end else if (raw_mode && frame_start) begin
        frame_num_r <= frame_num_nxt;
        frame_number <= frame_num_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Trigger generator

  trigger_gen u_trigger_gen (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .enable(trig_ctl_r[BIT_GEN_EN]),
    .duty_even(trig_ctl_r[BIT_DUTY]),
    .high_count({8'h00, trig_high_lsb_r}),
    .low_count({trig_low_msb_r, trig_low_lsb_r}),
    .even_count({trig_high_lsb_r, trig_low_msb_r, trig_low_lsb_r}),
    .trigger(camera_trigger_signal)
  );

  ////////////////////////////////////////////////////////////////////
  // Read path and acknowledge

  function automatic logic [REG_W-1:0] read_reg(input logic [5:0] which);
    if (which == IDX_TRIG_LOW_LSB) begin
      read_reg = trig_low_lsb_r;
    end else if (which == IDX_WRAP_MSB) begin
      read_reg = wrap_msb_r;
    end else if (which == IDX_WRAP_LSB) begin
      read_reg = wrap_lsb_r;
    end else if (which == IDX_CLK_CTL) begin
      read_reg = {4'h0, clk_cfg_r} & CLK_CTL_MASK;
    end else if (which == IDX_TRIG_LOW_MSB) begin
      read_reg = trig_low_msb_r;
    end else if (which == IDX_TRIG_HIGH_LSB) begin
      read_reg = trig_high_lsb_r;
    end else if (which == IDX_TRIG_CTL) begin
      read_reg = trig_ctl_r;
    end else if (which == IDX_FRAME_NUM) begin
      read_reg = frame_num_r[7:0];
    end else begin
      read_reg = RST_ZERO;
    end
  endfunction : read_reg

  // One ack per access, a cycle after the request; unmapped addresses ack with zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_r <= BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce) begin
      case (bus_r)
        BUS_IDLE: begin
          wb_ack_o <= take;
          if (take) begin
            bus_r <= BUS_ACK;
            wb_dat_o <= {24'h000000, read_reg(idx)};
          end
        end
        BUS_ACK: begin
          wb_ack_o <= 1'b0;
          bus_r <= BUS_IDLE;
        end
        default: begin
          wb_ack_o <= 1'b0;
          bus_r <= BUS_IDLE;
        end
      endcase
    end
  end

endmodule : frame_regs

// ### bench/frame_regs_asserts.sv
/*
  Port checker for frame_regs, bound to every instance.
  Assumes a bus master that holds each request until it sees ack.
*/
`timescale 1ns/1ns
module frame_regs_asserts
  import frame_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic raw_mode,
  input wire logic frame_start,
  input wire logic [FRAME_W-1:0] frame_number,
  input wire logic frame_number_valid,
  input wire logic internal_oscillator_select,
  input wire logic ref_clk_half,
  input wire logic [1:0] lane_rate
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  logic cw;
  logic [3:0] co;
  logic fr;
  assign cw = wb_ack_o && wb_we_i && wb_sel_i[0] &&
    wb_adr_i[7:2] == IDX_CLK_CTL;
  assign co = {internal_oscillator_select, ref_clk_half, lane_rate};
  assign fr = frame_start && raw_mode && ce;
  //////////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_delay_a: assert property (
    ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  read_width_a: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  rsvd_zero_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[7:2] == IDX_CLK_CTL
    |-> wb_dat_o[7:4] == 4'h0) else $error("reserved bits set");
  clk_apply_a: assert property (
    cw |=> co == $past(wb_dat_i[3:0])) else $error("clock cfg wrong");
  clk_hold_a: assert property ($changed(co) |-> $past(cw))
    else $error("clock cfg moved");
  frame_step_a: assert property (
    fr |=> frame_number == $past(frame_number) + 16'h0001 ||
    frame_number <= 16'h0001) else $error("frame step wrong");
  frame_hold_a: assert property (
    !fr && !wb_ack_o |=> $stable(frame_number) ||
    frame_number == 16'h0000) else $error("frame number moved");
  valid_lag_a: assert property (
    $past(ce) |-> frame_number_valid == $past(raw_mode))
    else $error("valid lag wrong");
  cover property (cw);
  cover property (fr && frame_number > 16'h0001 ##1
    frame_number == 16'h0001);
  cover property (wb_ack_o && !wb_we_i);
endmodule : frame_regs_asserts

bind frame_regs frame_regs_asserts chk (.*);

// ### bench/frame_sink.sv
/*
  Downstream frame sink: asks for a frame, then captures the number
  carried by its start packet. Assumes the single clk domain.
*/
`timescale 1ns/1ns
module frame_sink
  import frame_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic send,
  input wire logic [FRAME_W-1:0] frame_number,
  output logic frame_start,
  output logic [FRAME_W-1:0] seen
);
  logic taken_r;
  // Read a cycle after the pulse: the number updates on that edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_start <= 1'b0;
      taken_r <= 1'b0;
      seen <= 16'hffff;
    end else begin
      frame_start <= send;
      taken_r <= frame_start;
      if (taken_r) begin
        seen <= frame_number;
      end
    end
  end
endmodule : frame_sink

// ### bench/frame_regs_tb.sv
/*
  Bench for frame_regs: Wishbone tasks, frame sink, trigger timing.
  Assumes the bound checker and the frame_sink model.
*/
`timescale 1ns/1ns
`define CHK(n, x, g) begin checks++; if ((g) !== (x)) begin \
  mismatches++; $display("Error %s exp %h got %h", n, x, g); end end
module frame_regs_tb
  import frame_regs_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, raw = 1'b0, send = 1'b0;
  logic [3:0] sel = 4'h1, bsel = 4'h1;
  logic [7:0] adr = 8'h00;
  logic [7:0] d;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, fs, osc, half, trig;
  logic [1:0] rate;
  logic [15:0] num, seen, e;
  int mismatches = 0, checks = 0, cycles = 0;
  //////////////////////////////////////////////////////////////////////
  frame_regs dut (.clk(clk), .rst(rst), .ce(ce), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .raw_mode(raw),
    .frame_start(fs), .frame_number(num), .frame_number_valid(),
    .internal_oscillator_select(osc), .ref_clk_half(half),
    .lane_rate(rate), .camera_trigger_signal(trig));
  frame_sink sink (.clk(clk), .rst(rst), .send(send),
    .frame_number(num), .frame_start(fs), .seen(seen));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up;
    end
  end
  //////////////////////////////////////////////////////////////////////
  task wrap_up;
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic wb(input logic [7:0] a, input logic w,
    input logic [7:0] v);
    @(posedge clk);
    adr <= a;
    we <= w;
    sel <= bsel;
    wdat <= {24'h000000, v};
    cyc <= 1'b1;
    stb <= 1'b1;
    // Only the bench timeout ends a wait for ack
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    wb(a, 1'b0, 8'h00);
    `CHK("read", {24'h000000, x}, q)
  endtask : rd
  task automatic frames(input int cnt, input logic [15:0] lim);
    for (int k = 0; k < cnt; k++) begin
      e = (lim == 16'h0) ? 16'h0 : (e == lim) ? 16'h1 : e + 16'h1;
      @(posedge clk);
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK("frame number", e, seen)
    end
  endtask : frames
  task automatic span(input logic lvl, output int n);
    n = 0;
    while (trig === lvl && n < 999) begin
      @(posedge clk);
      n++;
    end
  endtask : span
  // Skip two phases first: a count change also retimes the phase in progress
  task automatic trig_meas(input int hi, input int lo);
    int n;
    span(1'b1, n);
    span(1'b0, n);
    span(1'b1, n);
    `CHK("trigger high", hi, n)
    span(1'b0, n);
    `CHK("trigger low", lo, n)
  endtask : trig_meas
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    `CHK("clock cfg", 4'h2, {osc, half, rate})
    rd(8'h70, 8'h00);
    rd(8'h74, 8'h00);
    rd(8'h78, 8'h04);
    rd(8'h7c, 8'h02);
    rd(8'hfc, 8'h00);
    wb(8'h74, 1'b1, 8'ha5);
    rd(8'h74, 8'ha5);
    bsel = 4'h0;
    wb(8'h78, 1'b1, 8'hff);
    bsel = 4'h1;
    rd(8'h78, 8'h04);
    for (int i = 0; i < 4; i++) begin
      // Half rate never paired with the slowest lane rate
      d = {4'hf, ~i[1:0], i[1:0]};
      wb(8'h7c, 1'b1, d);
      @(posedge clk);
      `CHK("clock cfg", d[3:0], {osc, half, rate})
      rd(8'h7c, {4'h0, d[3:0]});
    end
    wb(8'h74, 1'b1, 8'h00);
    wb(8'h78, 1'b1, 8'h03);
    raw <= 1'b1;
    e = 16'h0;
    frames(7, 16'h3);
    wb(8'h74, 1'b1, 8'h01);
    frames(3, 16'h103);
    // A frame while the clock enable is low must not advance the count
    ce <= 1'b0;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("frozen number", e, seen)
    ce <= 1'b1;
    wb(8'h74, 1'b1, 8'h00);
    wb(8'h78, 1'b1, 8'h00);
    frames(2, 16'h0);
    rd(8'h84, 8'h00);
    wb(8'h70, 1'b1, 8'h03);
    wb(8'h6c, 1'b1, 8'h01);
    wb(8'h80, 1'b1, 8'h01);
    trig_meas(1, 260);
    wb(8'h80, 1'b1, 8'h03);
    trig_meas(260, 260);
    wrap_up;
  end
endmodule : frame_regs_tb
